// [verilog/time_aware_gate_scheduler.sv]
// Time-aware egress gate scheduler with APB configuration and strict-priority pick
`timescale 1ns/1ps

module time_aware_gate_scheduler #(
    parameter int NUM_PORTS = tas_pkg::NUM_PORTS,
    parameter int NUM_GATES = tas_pkg::NUM_GATES,
    parameter int NUM_SLOTS = tas_pkg::NUM_SLOTS,
    parameter int NUM_CYCLES = tas_pkg::NUM_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Queue occupancy, one bit per port and traffic class
    input wire logic [NUM_PORTS*NUM_GATES-1:0] queue_nonempty,
    // Selection towards transmit MACs
    output logic [NUM_PORTS*NUM_GATES-1:0] gate_open,
    output logic [NUM_PORTS-1:0] pick_valid,
    output logic [NUM_PORTS*3-1:0] pick_class
);
    // Elaboration check on sizes the logic serves
    initial begin
        // Slot entry layout and the 3-bit class field fix the port and gate counts
        if (NUM_PORTS != tas_pkg::NUM_PORTS || NUM_GATES != tas_pkg::NUM_GATES) begin
            $error("Unsupported port or gate count");
        end
        // The slot pointer cannot reach beyond its own width
        if (NUM_SLOTS < 1 || NUM_SLOTS > (1 << tas_pkg::SLOT_IDX_W)) begin
            $error("Unsupported slot table depth");
        end
        // Cycle registers are selected by a 3-bit address field
        if (NUM_CYCLES < 1 || NUM_CYCLES > 8) begin
            $error("Unsupported cycle count");
        end
    end

    // Width of the cycle or port index taken from the address
    localparam int CW = 3;
    // Slot table memory, shared among all cycles
    tas_pkg::slot_s slot_mem [NUM_SLOTS];
    logic [tas_pkg::SLOT_IDX_W-1:0] entry_q [NUM_CYCLES]; // Cycle start index
    logic [tas_pkg::SLOT_IDX_W-1:0] end_q [NUM_CYCLES];   // Cycle end index
    logic [NUM_CYCLES-1:0] cyc_en_q;                      // Entry-point enable
    logic run_q;                                          // Global enable
    logic [tas_pkg::SLOT_IDX_W-1:0] slot_idx_q;           // Table access pointer
    tas_pkg::slot_s slot_wr_q;                            // Staged entry
    // Per-cycle running state
    logic [tas_pkg::SLOT_IDX_W-1:0] cur_q [NUM_CYCLES];
    logic [tas_pkg::DUR_W-1:0] left_q [NUM_CYCLES];
    // A cycle is active from its first tick until run or its enable drops
    logic [NUM_CYCLES-1:0] active_q;
    // Tick divider state and its one-cycle enable pulse
    logic [1:0] div_q;
    logic tick;
    // Internal gate state per port; gate_open is its registered copy
    logic [NUM_GATES-1:0] gates_q [NUM_PORTS];

    // Register offset decode used by reads and writes
    // Each bank spans eight words, one per cycle or per port
    function automatic logic in_bank(input logic [11:0] a, input logic [11:0] base);
        return (a >= base) && (a < base + 12'h020);
    endfunction

    // Access phase; a write lands at the edge that ends it
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire [CW-1:0] bidx = paddr[4:2];

    // Tick divider: one pulse every 200 ns
    // Runs free from reset so every cycle engine shares one tick phase;
    // a clock period that does not divide the tick period rounds the tick up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 2'h0;
        end else if (div_q == 2'(tas_pkg::TICK_DIV - 1)) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end
    // High on the last clock of each tick period
    assign tick = (div_q == 2'(tas_pkg::TICK_DIV - 1));

    // Configuration registers written over APB
    // Writes to read-only or unmapped offsets fall through and change nothing;
    // index tables may be rewritten while running and count at the next boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
            cyc_en_q <= '0;
            slot_idx_q <= '0;
            slot_wr_q <= '0;
            for (int i = 0; i < NUM_CYCLES; i++) begin
                entry_q[i] <= '0;
                end_q[i] <= '0;
            end
        end else if (wr) begin
            if (paddr == tas_pkg::REG_CTRL) begin
                run_q <= pwdata[tas_pkg::CTRL_EN_BIT];
            end else if (paddr == tas_pkg::REG_SLOT_IDX) begin
                slot_idx_q <= pwdata[tas_pkg::SLOT_IDX_W-1:0];
            end else if (paddr == tas_pkg::REG_SLOT_PORTS_GATES) begin
                slot_wr_q.gates <= pwdata[tas_pkg::GATES_LSB +: NUM_GATES];
                slot_wr_q.ports <= pwdata[tas_pkg::PORTS_LSB +: NUM_PORTS];
            end else if (in_bank(paddr, tas_pkg::REG_ENTRY_BASE) && 32'(bidx) < NUM_CYCLES) begin
                entry_q[bidx] <= pwdata[tas_pkg::SLOT_IDX_W-1:0];
            end else if (in_bank(paddr, tas_pkg::REG_END_BASE) && 32'(bidx) < NUM_CYCLES) begin
                end_q[bidx] <= pwdata[tas_pkg::SLOT_IDX_W-1:0];
            end else if (in_bank(paddr, tas_pkg::REG_EPARAM_BASE) && 32'(bidx) < NUM_CYCLES) begin
                cyc_en_q[bidx] <= pwdata[tas_pkg::EPARAM_EN_BIT];
            end
        end
    end

    // Slot memory write: duration write commits the staged entry
    // The memory has no reset, so every slot a cycle can reach must be loaded
    // before the cycle is enabled, or stale entries would drive the gates
    always_ff @(posedge pclk) begin
        if (wr && paddr == tas_pkg::REG_SLOT_DUR && 32'(slot_idx_q) < NUM_SLOTS) begin
            slot_mem[slot_idx_q] <= '{ports: slot_wr_q.ports, gates: slot_wr_q.gates,
                                      dur: pwdata[tas_pkg::DUR_W-1:0]};
        end
    end

    // Cycle engines: each counts ticks down independently
    // All engines read the slot memory in the same clock, so the table is a
    // register array rather than a single-port memory
    // A slot expires when its count reaches one on a tick; the next index
    // wraps from end to entry, so linkage comes only from the two tables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_q <= '0;
            for (int c = 0; c < NUM_CYCLES; c++) begin
                cur_q[c] <= '0;
                left_q[c] <= '0;
            end
        end else begin
            for (int c = 0; c < NUM_CYCLES; c++) begin
                if (!run_q || !cyc_en_q[c]) begin
                    // Stopped: rewind to the start index; gates keep their last state
                    active_q[c] <= 1'b0;
                    cur_q[c] <= entry_q[c];
                    left_q[c] <= '0;
                end else if (!active_q[c] && tick) begin
                    // Start on a tick so the first slot is as long as the later ones
                    // and the gates never move between tick boundaries
                    active_q[c] <= 1'b1;
                    left_q[c] <= slot_mem[entry_q[c]].dur;
                end else if (tick && left_q[c] <= 1) begin
                    // Slot boundary: advance to next slot
                    if (cur_q[c] == end_q[c]) begin
                        // Last slot done: wrap to the start index
                        cur_q[c] <= entry_q[c];
                        left_q[c] <= slot_mem[entry_q[c]].dur;
                    end else begin
                        // Next slot in table order
                        cur_q[c] <= cur_q[c] + 1'b1;
                        left_q[c] <= slot_mem[cur_q[c] + 1'b1].dur;
                    end
                end else if (tick) begin
                    left_q[c] <= left_q[c] - 1'b1;
                end
            end
        end
    end

    // Slot start events per cycle; overlap across cycles is the software's duty
    // Mirrors the engine decisions so the gates load at the very edge at which
    // an engine moves to a new slot
    logic [NUM_CYCLES-1:0] start_ev;
    logic [tas_pkg::SLOT_IDX_W-1:0] start_idx [NUM_CYCLES];
    always_comb begin
        for (int c = 0; c < NUM_CYCLES; c++) begin
            start_ev[c] = 1'b0;
            start_idx[c] = entry_q[c];
            if (run_q && cyc_en_q[c]) begin
                if (!active_q[c]) begin
                    start_ev[c] = tick; // First slot loads on a tick
                end else if (tick && left_q[c] <= 1) begin
                    start_ev[c] = 1'b1;
                    start_idx[c] = (cur_q[c] == end_q[c]) ? entry_q[c] : cur_q[c] + 1'b1;
                end
            end
        end
    end

    // Gate state per port: applied only at slot starts, only on selected ports
    // If two cycles did start together the lowest-numbered one would win
    // Ports that the starting slot does not name keep what an earlier slot left
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                gates_q[p] <= tas_pkg::GATE_RST; // Open, so traffic flows before a schedule runs
            end
        end else begin
            for (int c = NUM_CYCLES - 1; c >= 0; c--) begin
                if (start_ev[c]) begin
                    for (int p = 0; p < NUM_PORTS; p++) begin
                        if (slot_mem[start_idx[c]].ports[p]) begin
                            gates_q[p] <= slot_mem[start_idx[c]].gates;
                        end
                    end
                end
            end
        end
    end

    // Eligibility and strict-priority pick per port
    // gate_open and the pick both follow the same gates_q value, so a pick never
    // names a class whose gate is shown closed in the same cycle; occupancy is
    // taken as it stood one clock before the pick appears
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
            // Eligible: gate open and queue holding frames
            wire [NUM_GATES-1:0] elig = gates_q[gp] & queue_nonempty[gp*NUM_GATES +: NUM_GATES];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    gate_open[gp*NUM_GATES +: NUM_GATES] <= tas_pkg::GATE_RST;
                    pick_valid[gp] <= 1'b0;
                    pick_class[gp*3 +: 3] <= 3'h0;
                end else begin
                    gate_open[gp*NUM_GATES +: NUM_GATES] <= gates_q[gp];
                    pick_valid[gp] <= |elig;
                    pick_class[gp*3 +: 3] <= 3'h0;
                    // Ascending scan so the highest class index wins
                    for (int g = 0; g < NUM_GATES; g++) begin
                        if (elig[g]) begin
                            pick_class[gp*3 +: 3] <= 3'(g);
                        end
                    end
                end
            end
        end
    endgenerate

    // APB read data and response; zero-wait, unmapped reads zero with error
    // The answer is prepared from the setup cycle and stands for exactly the
    // access cycle; read data is a snapshot, so a write in that same access
    // is not reflected until the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= tas_pkg::RDATA_RST;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= tas_pkg::RDATA_RST;
            if (psel && !penable) begin
                if (paddr == tas_pkg::REG_CTRL) begin
                    prdata <= 32'(run_q);
                end else if (paddr == tas_pkg::REG_STATUS) begin
                    prdata <= 32'(active_q);
                end else if (paddr == tas_pkg::REG_SLOT_IDX) begin
                    prdata <= 32'(slot_idx_q);
                end else if (paddr == tas_pkg::REG_SLOT_PORTS_GATES) begin
                    // Slot fields come from the memory at the access pointer
                    prdata <= {19'h0, slot_mem[slot_idx_q].ports, slot_mem[slot_idx_q].gates};
                end else if (paddr == tas_pkg::REG_SLOT_DUR) begin
                    prdata <= 32'(slot_mem[slot_idx_q].dur);
                end else if (in_bank(paddr, tas_pkg::REG_ENTRY_BASE) && 32'(bidx) < NUM_CYCLES) begin
                    prdata <= 32'(entry_q[bidx]);
                end else if (in_bank(paddr, tas_pkg::REG_END_BASE) && 32'(bidx) < NUM_CYCLES) begin
                    prdata <= 32'(end_q[bidx]);
                end else if (in_bank(paddr, tas_pkg::REG_EPARAM_BASE) && 32'(bidx) < NUM_CYCLES) begin
                    prdata <= 32'(cyc_en_q[bidx]);
                end else if (in_bank(paddr, tas_pkg::REG_GATE_BASE) && 32'(bidx) < NUM_PORTS) begin
                    prdata <= 32'(gates_q[bidx]);
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end
endmodule

// [inc/tas_pkg.sv]
// Package with constants, types and register map of the gate scheduler
package tas_pkg;
    localparam int NUM_PORTS = 5;
    localparam int NUM_GATES = 8;
    localparam int NUM_SLOTS = 1024;
    localparam int NUM_CYCLES = 8;
    localparam int SLOT_IDX_W = 10;
    localparam int DUR_W = 18;
    // Tick period and clock period in nanoseconds
    localparam int TICK_NS = 200;
    localparam int CLK_NS = 100;
    localparam int TICK_DIV = (TICK_NS + CLK_NS - 1) / CLK_NS;
    // Register offsets (byte addresses)
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_SLOT_IDX = 12'h008;
    localparam logic [11:0] REG_SLOT_PORTS_GATES = 12'h00c;
    localparam logic [11:0] REG_SLOT_DUR = 12'h010;
    localparam logic [11:0] REG_ENTRY_BASE = 12'h040;
    localparam logic [11:0] REG_END_BASE = 12'h060;
    localparam logic [11:0] REG_EPARAM_BASE = 12'h080;
    localparam logic [11:0] REG_GATE_BASE = 12'h0a0;
    // Field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int GATES_LSB = 0;
    localparam int PORTS_LSB = 8;
    localparam int EPARAM_EN_BIT = 0;
    // Reset values
    localparam logic [NUM_GATES-1:0] GATE_RST = 8'hff;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    // Slot table entry
    typedef struct packed {
        logic [NUM_PORTS-1:0] ports;
        logic [NUM_GATES-1:0] gates;
        logic [DUR_W-1:0] dur;
    } slot_s;
endpackage

// [testbench/tas_sva.sv]
// Port-level checker for the gate scheduler
`timescale 1ns/1ps
module tas_sva #(
    parameter int NUM_PORTS = 5,
    parameter int NUM_GATES = 8,
    parameter int NUM_SLOTS = 1024,
    parameter int NUM_CYCLES = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Queues and selection
    input wire logic [NUM_PORTS*NUM_GATES-1:0] queue_nonempty,
    input wire logic [NUM_PORTS*NUM_GATES-1:0] gate_open,
    input wire logic [NUM_PORTS-1:0] pick_valid,
    input wire logic [NUM_PORTS*3-1:0] pick_class
);
    logic [7:0] qne_q; // Port 0 occupancy one clock back, as the pick saw it
    logic any_open; // Port 0 has an open gate over a non-empty queue
    logic [2:0] hi_open; // Highest such class
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Occupancy is delayed one clock; the gates shown now are those the pick used
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qne_q <= 8'h00;
        end else begin
            qne_q <= queue_nonempty[7:0];
        end
    end
    // Reference pick for port 0; later loop passes win, so the top class remains
    always_comb begin
        any_open = |(gate_open[7:0] & qne_q);
        hi_open = 3'h0;
        for (int g = 0; g < 8; g++) begin
            if (gate_open[g] && qne_q[g]) begin
                hi_open = 3'(g);
            end
        end
    end
    AST_APB_READY: assert property (psel && !penable |=> pready) else $error("no pready after setup");
    AST_READY_PULSE: assert property (pready |=> !pready) else $error("pready held too long");
    AST_ERR_READY: assert property (pslverr |-> pready) else $error("pslverr without pready");
    AST_UNMAPPED: assert property (psel && !penable && paddr >= 12'h0b4 |=> pslverr) else $error("no error");
    AST_PICK_VALID: assert property (pick_valid[0] == any_open) else $error("pick valid wrong");
    AST_PICK_CLASS: assert property (pick_valid[0] |-> pick_class[2:0] == hi_open) else $error("bad class");
    AST_IDLE_CLASS: assert property (!pick_valid[0] |-> pick_class[2:0] == 3'h0) else $error("idle class");
    AST_GATE_HOLD: assert property ($changed(gate_open) |=> $stable(gate_open)) else $error("gate glitch");
endmodule

bind time_aware_gate_scheduler tas_sva #(.NUM_PORTS(NUM_PORTS), .NUM_GATES(NUM_GATES), .NUM_SLOTS(NUM_SLOTS),
    .NUM_CYCLES(NUM_CYCLES)) u_tas_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .queue_nonempty(queue_nonempty), .gate_open(gate_open), .pick_valid(pick_valid), .pick_class(pick_class));

// [testbench/queue_model.sv]
// Model of the egress queues feeding the scheduler
`timescale 1ns/1ps
module queue_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Occupancy wanted by the bench
    input wire logic [39:0] fill,
    // Occupancy flags seen by the scheduler
    output logic [39:0] queue_nonempty
);
    // Flags move on the clock like real FIFO flags; bit p*8+g is priority g of port p
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            queue_nonempty <= 40'h0; // Queues empty after reset
        end else begin
            queue_nonempty <= fill;
        end
    end
endmodule

// [testbench/time_aware_gate_scheduler_tb.sv]
// Self-checking bench for the gate scheduler
`timescale 1ns/1ps
module time_aware_gate_scheduler_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [39:0] fill = 40'h0; // Wanted queue occupancy
    logic [39:0] queue_nonempty, gate_open;
    logic [4:0] pick_valid;
    logic [14:0] pick_class;
    int num_errors = 0;
    int cmp_count = 0;
    always #50 pclk = ~pclk; // 10 MHz
    time_aware_gate_scheduler u_time_aware_gate_scheduler (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .queue_nonempty(queue_nonempty), .gate_open(gate_open), .pick_valid(pick_valid),
        .pick_class(pick_class));
    queue_model u_queue_model (.pclk(pclk), .presetn(presetn), .fill(fill), .queue_nonempty(queue_nonempty));
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; for a read d is the expected data, err the expected error flag
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Values read right after the edge are those sampled at it
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            print_verdict();
        end
        if (!w) check(prdata, d);
        check(pslverr, err);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Wait, bounded, until port 0 shows the given gates
    task automatic wait_gates(input logic [7:0] g);
        for (int n = 0; n < 100; n++) begin
            @(posedge pclk);
            #1;
            if (gate_open[7:0] === g) return;
        end
        num_errors++;
        print_verdict();
    endtask
    // Reset values, refused offsets and loading of the four tables
    task automatic t_regs();
        apb(1'b0, tas_pkg::REG_GATE_BASE, 32'h0000_00ff, 1'b0);
        apb(1'b0, tas_pkg::REG_GATE_BASE + 12'h010, 32'h0000_00ff, 1'b0);
        apb(1'b0, tas_pkg::REG_GATE_BASE + 12'h014, 32'h0, 1'b1);
        apb(1'b0, tas_pkg::REG_STATUS, 32'h0, 1'b0);
        apb(1'b1, 12'h014, 32'hffff_ffff, 1'b1);
        apb(1'b0, 12'h014, 32'h0, 1'b1);
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, tas_pkg::REG_SLOT_IDX, 32'(s), 1'b0);
            apb(1'b1, tas_pkg::REG_SLOT_PORTS_GATES, (s == 0) ? 32'h0120 : 32'h0108, 1'b0);
            apb(1'b1, tas_pkg::REG_SLOT_DUR, 32'h3, 1'b0);
            apb(1'b0, tas_pkg::REG_SLOT_PORTS_GATES, (s == 0) ? 32'h0120 : 32'h0108, 1'b0);
            apb(1'b0, tas_pkg::REG_SLOT_DUR, 32'h3, 1'b0);
        end
        apb(1'b1, tas_pkg::REG_ENTRY_BASE, 32'h0, 1'b0);
        apb(1'b1, tas_pkg::REG_END_BASE, 32'h1, 1'b0);
        apb(1'b0, tas_pkg::REG_END_BASE, 32'h1, 1'b0);
        apb(1'b1, tas_pkg::REG_EPARAM_BASE, 32'h1, 1'b0);
        $display("test regs done");
    endtask
    // Two-slot cycle on port 0: gates, durations, wrap and strict-priority pick
    task automatic t_sched();
        int n;
        fill <= 40'h00_0000_2828; // Classes 3 and 5 waiting on ports 0 and 1
        apb(1'b1, tas_pkg::REG_CTRL, 32'h1, 1'b0);
        wait_gates(8'h20);
        check(gate_open[39:8], 32'hffff_ffff);
        @(posedge pclk);
        #1;
        check(pick_class[2:0], 3'h5);
        check(pick_class[5:3], 3'h5);
        wait_gates(8'h08);
        check(pick_class[2:0], 3'h3);
        n = 0;
        while (gate_open[7:0] === 8'h08 && n < 100) begin
            n++;
            @(posedge pclk);
            #1;
        end
        check(40'(n), 40'(3 * tas_pkg::TICK_DIV));
        check(gate_open[7:0], 8'h20);
        check(pick_class[2:0], 3'h5);
        apb(1'b0, tas_pkg::REG_STATUS, 32'h1, 1'b0);
        fill <= 40'h00_0000_0001; // Only class 0, closed in both slots
        repeat (3) @(posedge pclk);
        #1;
        check(pick_valid, 5'h00);
        check(pick_class, 15'h0000);
        apb(1'b1, tas_pkg::REG_CTRL, 32'h0, 1'b0);
        $display("test sched done");
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_sched();
        print_verdict();
    end
endmodule
